// [rtl/scu_regs.svh]
/*
 * Register offsets, field positions, reset values and timing counts of the serial
 * communication unit. Definitions only; included by the package and the modules.
 */
`ifndef SCU_REGS_SVH
`define SCU_REGS_SVH

// Register byte offsets on the APB (one aligned 32-bit word each).
`define SCU_OFF_MODE    8'h00
`define SCU_OFF_CTRL    8'h04
`define SCU_OFF_BRR     8'h08
`define SCU_OFF_TDR     8'h0C
`define SCU_OFF_RDR     8'h10
`define SCU_OFF_STATUS  8'h14
`define SCU_OFF_CLEAR   8'h18
`define SCU_OFF_IEN     8'h1C
`define SCU_OFF_FLAGS   8'h20

// Field positions in serial_mode_config.
`define SCU_MB_SYNC     7
`define SCU_MB_CHR      6
`define SCU_MB_PE       5
`define SCU_MB_ODD      4
`define SCU_MB_STOP     3
`define SCU_MB_MP       2

// Field positions in serial_control.
`define SCU_CB_CLOCK_ENABLE_0     0
`define SCU_CB_CLOCK_ENABLE_1     1
`define SCU_CB_MPB_TX   2
`define SCU_CB_RE       4
`define SCU_CB_TE       5

// Event bit positions shared by status, clear and enable registers.
`define SCU_EV_RXF      0
`define SCU_EV_TXE      1
`define SCU_EV_TEND     2
`define SCU_EV_OVERRUN_ERROR_FLAG     3
`define SCU_EV_PER      4
`define SCU_EV_FER      5
`define SCU_EV_W        6

// Field positions in the live flag register.
`define SCU_FB_TDRE     0
`define SCU_FB_RDRF     1
`define SCU_FB_TEND     2
`define SCU_FB_RXBUSY   3
`define SCU_FB_TXBUSY   4

// Reset values.
`define SCU_RST_MODE    8'h00
`define SCU_RST_CTRL    8'h00
`define SCU_RST_BRR     8'h03
`define SCU_RST_DATA    8'h00

// Oversampling: sixteen ticks per bit, centre sample on the eighth tick.
`define SCU_OVS_LAST    4'hF
`define SCU_SAMPLE_PT   4'h7
`define SCU_SYNC_LAST   4'h7
`define SCU_DATA8       4'h8
`define SCU_DATA7       4'h7

`endif

// [rtl/scu_pkg.sv]
/*
 * Types and shared decode functions of the serial communication unit.
 * Assumes scu_regs.svh is on the include path.
 */
`include "scu_regs.svh"

package scu_pkg;

  // Effective character format after mode overrides are applied.
  typedef struct packed {
    logic sync;
    logic seven;
    logic par_en;
    logic par_odd;
    logic two_stop;
    logic mp_en;
  } scu_fmt_t;

  // One received character with its check results.
  typedef struct packed {
    logic [7:0] data;
    logic       extra;
    logic       par_err;
    logic       frm_err;
  } scu_rx_res_t;

  typedef enum logic [1:0] {
    SCU_TX_IDLE  = 2'b01,
    SCU_TX_SHIFT = 2'b10
  } scu_tx_st_t;

  typedef enum logic [2:0] {
    SCU_RX_IDLE  = 3'b001,
    SCU_RX_START = 3'b010,
    SCU_RX_BITS  = 3'b100
  } scu_rx_st_t;

  // Synchronous mode forces 8 bits with nothing else; the MP bit displaces parity.
  function automatic scu_fmt_t decode_fmt(input logic [7:0] mode);
    scu_fmt_t f;
    f.sync     = mode[`SCU_MB_SYNC];
    f.seven    = !f.sync && mode[`SCU_MB_CHR];
    f.mp_en    = !f.sync && mode[`SCU_MB_MP];
    f.par_en   = !f.sync && !f.mp_en && mode[`SCU_MB_PE];
    f.par_odd  = mode[`SCU_MB_ODD];
    f.two_stop = !f.sync && mode[`SCU_MB_STOP];
    return f;
  endfunction

  // Parity bit that makes the count of ones even, or odd when odd is set.
  function automatic logic par_bit(input logic [7:0] d, input logic seven, input logic odd);
    logic [7:0] m;
    m = seven ? {1'b0, d[6:0]} : d;
    return (^m) ^ odd;
  endfunction

  function automatic logic [3:0] data_len(input scu_fmt_t f);
    return f.seven ? `SCU_DATA7 : `SCU_DATA8;
  endfunction

endpackage

// [rtl/scu_baud.sv]
/*
 * Clock source of the serial unit: an internal divider giving the sixteen-times
 * tick, or edges of the serial clock pin. The pin is taken as synchronous to pclk.
 */
`timescale 1ns/10ps
`include "scu_regs.svh"

module scu_baud #(
  parameter int DIV_W = 8
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Configuration.
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             use_ext,
  // Serial clock pin level.
  input  wire logic             sck_in,
  // Timing strobes.
  output logic                  tick16,
  output logic                  sck_rise,
  output logic                  sck_fall
);

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic             sck_prev_r;
  logic             tick_nxt;
  logic             rise_nxt;
  logic             fall_nxt;

  // Divider wraps at the programmed value; external mode holds it at zero and passes each pin rising edge on as the tick.
  always_comb begin
    rise_nxt = sck_in && !sck_prev_r;
    fall_nxt = !sck_in && sck_prev_r;
    if (use_ext || cnt_r >= divisor) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + DIV_W'(1);
    end
    tick_nxt = use_ext ? rise_nxt : (cnt_r >= divisor);
  end

  // Strobes are registered so that each lasts exactly one pclk cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r      <= '0;
      sck_prev_r <= 1'b1;
      tick16     <= 1'b0;
      sck_rise   <= 1'b0;
      sck_fall   <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      sck_prev_r <= sck_in;
      tick16     <= tick_nxt;
      sck_rise   <= rise_nxt;
      sck_fall   <= fall_nxt;
    end
  end

endmodule

// [rtl/scu_rx.sv]
/*
 * Receive shift section of the serial unit. Produces one registered pulse per
 * character with the data and its checks; the holding buffer lives in the top.
 */
`timescale 1ns/10ps
`include "scu_regs.svh"

module scu_rx (
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Format and enable.
  input  wire scu_pkg::scu_fmt_t  fmt,
  input  wire logic               enable,
  // Line and timing.
  input  wire logic               rxd,
  input  wire logic               tick16,
  input  wire logic               sync_smp,
  // Result.
  output logic                    done,
  output scu_pkg::scu_rx_res_t    res,
  output logic                    busy
);

  scu_pkg::scu_rx_st_t  st_r,    st_nxt;
  logic [3:0]           os_r,    os_nxt;
  logic [3:0]           idx_r,   idx_nxt;
  logic [9:0]           sh_r,    sh_nxt;
  logic                 prev_r,  prev_nxt;
  logic                 done_nxt;
  scu_pkg::scu_rx_res_t res_nxt;
  logic [3:0]           nd;
  logic [3:0]           last;
  logic                 smp;

  // One state machine serves both modes; synchronous mode has its own sample strobe and skips the start state.
  always_comb begin
    st_nxt   = st_r;
    os_nxt   = os_r;
    idx_nxt  = idx_r;
    sh_nxt   = sh_r;
    prev_nxt = tick16 ? rxd : prev_r;
    done_nxt = 1'b0;
    res_nxt  = res;
    nd       = scu_pkg::data_len(fmt);
    last     = nd + 4'((fmt.par_en || fmt.mp_en) ? 1 : 0);
    smp      = fmt.sync ? sync_smp : (tick16 && os_r == `SCU_SAMPLE_PT);
    if (tick16) begin
      os_nxt = os_r + 4'h1;
    end
    case (st_r)
      scu_pkg::SCU_RX_IDLE: begin
        idx_nxt = '0;
        if (enable && fmt.sync && sync_smp) begin
          sh_nxt[0] = rxd;
          idx_nxt   = 4'h1;
          st_nxt    = scu_pkg::SCU_RX_BITS;
        end else if (enable && !fmt.sync && tick16 && prev_r && !rxd) begin
          os_nxt = 4'h1;
          st_nxt = scu_pkg::SCU_RX_START;
        end
      end
      scu_pkg::SCU_RX_START: begin
        if (smp) begin
          st_nxt = rxd ? scu_pkg::SCU_RX_IDLE : scu_pkg::SCU_RX_BITS;   // A high centre is a glitch.
        end
      end
      scu_pkg::SCU_RX_BITS: begin
        if (smp) begin
          sh_nxt[idx_r] = rxd;
          idx_nxt       = idx_r + 4'h1;
          if (fmt.sync ? (idx_r == `SCU_SYNC_LAST) : (idx_r == last)) begin
            st_nxt           = scu_pkg::SCU_RX_IDLE;
            done_nxt         = 1'b1;
            res_nxt.data     = fmt.seven ? {1'b0, sh_nxt[6:0]} : sh_nxt[7:0];
            res_nxt.extra    = sh_nxt[nd];
            res_nxt.par_err  = fmt.par_en &&
                               (sh_nxt[nd] != scu_pkg::par_bit(sh_nxt[7:0], fmt.seven, fmt.par_odd));
            res_nxt.frm_err  = !fmt.sync && !rxd;                       // Only the first stop is checked.
          end
        end
      end
      default: begin
        st_nxt = scu_pkg::SCU_RX_IDLE;
      end
    endcase
    if (!enable) begin
      st_nxt = scu_pkg::SCU_RX_IDLE;
    end
  end

  // State registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= scu_pkg::SCU_RX_IDLE;
      os_r   <= '0;
      idx_r  <= '0;
      sh_r   <= '0;
      prev_r <= 1'b1;
      done   <= 1'b0;
      res    <= '0;
    end else begin
      st_r   <= st_nxt;
      os_r   <= os_nxt;
      idx_r  <= idx_nxt;
      sh_r   <= sh_nxt;
      prev_r <= prev_nxt;
      done   <= done_nxt;
      res    <= res_nxt;
    end
  end

  assign busy = (st_r != scu_pkg::SCU_RX_IDLE);

endmodule

// [rtl/scu_top.sv]
/*
 * Serial communication unit: APB register file, interrupt logic, transmitter,
 * serial clock pin control, and instances of the clock source and receiver.
 * Assumes one 20 MHz pclk and pins that are synchronous to it.
 */
`timescale 1ns/10ps
`include "scu_regs.svh"

// Overview of operation
// - Synchronous characters are always eight data bits, no parity, MP or stop bit.
// - Synchronous receive reports overrun only.
// - Synchronous with clock_enable_1 clear: internal generator, clock driven out.
// - Synchronous with clock_enable_1 set: shift on the incoming pin clock.
// - Async: bit 6 selects 7 or 8 data, bit 5 parity, bit 3 stops.
// - Async: bit 2 puts a multiprocessor bit instead of parity.
// - Async internal clock; clock_enable_0 outputs a bit-rate clock on the pin.
// - Async clock_enable_1 set: pin supplies sixteen-times bit rate clock.
// - Frame order: low start, data LSB first, parity or MP, high stops.
// - Line idles high; reception starts on a fall to low.
// - Transmitter and receiver run independently, full duplex.
// - Each direction has a holding buffer apart from its shift register.
// - Receiver samples each bit on the eighth sixteen-times tick, or on the pin's rising edge in synchronous pin-clock mode.
// - Parity checked against the chosen even or odd sense.
module scu_top (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial data lines.
  output logic             txd,
  input  wire logic        rxd,
  // Serial clock pin.
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  // Interrupt.
  output logic             irq
);

  logic [7:0]            mode_r,  mode_nxt;
  logic [7:0]            ctrl_r,  ctrl_nxt;
  logic [7:0]            brr_r,   brr_nxt;
  logic [7:0]            tdr_r,   tdr_nxt;
  logic [7:0]            rdr_r,   rdr_nxt;
  logic [`SCU_EV_W-1:0]  sts_r,   sts_nxt;
  logic [`SCU_EV_W-1:0]  ien_r,   ien_nxt;
  logic                  tdre_r,  tdre_nxt;
  logic                  rdrf_r,  rdrf_nxt;
  logic                  tend_r,  tend_nxt;
  logic [31:0]           prdata_nxt;
  logic                  pready_nxt;
  logic                  pslverr_nxt;
  logic                  irq_nxt;
  scu_pkg::scu_tx_st_t   tx_st_r, tx_st_nxt;
  logic [10:0]           tx_sh_r, tx_sh_nxt;
  logic [3:0]            tx_cnt_r, tx_cnt_nxt;
  logic [3:0]            ph_r,    ph_nxt;
  logic                  txd_nxt;
  logic                  sck_o_nxt;
  logic                  sck_oe_nxt;
  logic                  tx_load;
  logic                  tx_end;
  logic                  tx_step;
  logic                  rx_smp;
  logic                  wr_en;
  logic                  rd_en;
  logic [`SCU_EV_W-1:0]  ev;
  scu_pkg::scu_fmt_t     fmt;
  logic                  ext_clk;
  logic                  tick16;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  rx_done;
  scu_pkg::scu_rx_res_t  rx_res;
  logic                  rx_busy;

  // Register fields as used by the logic.
  assign fmt     = scu_pkg::decode_fmt(mode_r);
  assign ext_clk = ctrl_r[`SCU_CB_CLOCK_ENABLE_1];
  assign wr_en   = psel && penable && pready && pwrite;
  assign rd_en   = psel && penable && pready && !pwrite;

  // Returns the frame bits after the start bit, first bit to go out in bit 0.
  function automatic logic [10:0] frame_bits(input scu_pkg::scu_fmt_t f, input logic [7:0] d,
                                             input logic multiproc_bit);
    logic [10:0] v;
    logic [3:0]  nd;
    v  = '1;                                                            // Stops are ones.
    nd = scu_pkg::data_len(f);
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < nd) begin
        v[i] = d[i];
      end
    end
    if (f.mp_en) begin
      v[nd] = multiproc_bit;
    end else if (f.par_en) begin
      v[nd] = scu_pkg::par_bit(d, f.seven, f.par_odd);
    end
    return v;
  endfunction

  // Count of bit times after the start bit.
  function automatic logic [3:0] frame_len(input scu_pkg::scu_fmt_t f);
    return scu_pkg::data_len(f) + 4'((f.par_en || f.mp_en) ? 1 : 0) + 4'(f.two_stop ? 2 : 1);
  endfunction

  // Clock source: divider, or the pin's own edges when clock_enable_1 is set.
  scu_baud #(
    .DIV_W    (8)
  ) u_baud (
    .pclk     (pclk),
    .presetn  (presetn),
    .divisor  (brr_r),
    .use_ext  (ext_clk),
    .sck_in   (sck_i),
    .tick16   (tick16),
    .sck_rise (sck_rise),
    .sck_fall (sck_fall)
  );

  // Receiver shift section; it never waits for the transmitter.
  scu_rx u_rx (
    .pclk     (pclk),
    .presetn  (presetn),
    .fmt      (fmt),
    .enable   (ctrl_r[`SCU_CB_RE]),
    .rxd      (rxd),
    .tick16   (tick16),
    .sync_smp (rx_smp),
    .done     (rx_done),
    .res      (rx_res),
    .busy     (rx_busy)
  );

  // Bit-time strobes: the phase counter runs on the sixteen-times tick; a synchronous
  // external clock shifts out on its falling edge and samples on its rising edge.
  always_comb begin
    ph_nxt = tick16 ? ph_r + 4'h1 : ph_r;
    if (fmt.sync && ext_clk) begin
      tx_step = sck_fall;
      rx_smp  = sck_rise;
    end else begin
      tx_step = tick16 && (ph_r == `SCU_OVS_LAST);
      rx_smp  = tick16 && (ph_r == `SCU_SAMPLE_PT);
    end
  end

  // Serial clock pin: rising edge at each bit centre; idle high in synchronous mode when neither TE nor RE is set.
  always_comb begin
    sck_oe_nxt = !ext_clk && (fmt.sync || ctrl_r[`SCU_CB_CLOCK_ENABLE_0]);
    if (fmt.sync && !(ctrl_r[`SCU_CB_TE] || ctrl_r[`SCU_CB_RE])) begin
      sck_o_nxt = 1'b1;
    end else begin
      sck_o_nxt = sck_oe_nxt && ph_nxt[3];
    end
  end

  // Transmitter: shift register fed from the holding register, back to back when full.
  always_comb begin
    tx_st_nxt  = tx_st_r;
    tx_sh_nxt  = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    txd_nxt    = txd;
    tx_load    = 1'b0;
    tx_end     = 1'b0;
    case (tx_st_r)
      scu_pkg::SCU_TX_IDLE: begin
        txd_nxt = 1'b1;
        if (tx_step && ctrl_r[`SCU_CB_TE] && !tdre_r) begin
          tx_load = 1'b1;
        end
      end
      scu_pkg::SCU_TX_SHIFT: begin
        if (tx_step) begin
          if (tx_cnt_r != 4'h0) begin
            txd_nxt    = tx_sh_r[0];
            tx_sh_nxt  = {1'b1, tx_sh_r[10:1]};
            tx_cnt_nxt = tx_cnt_r - 4'h1;
          end else if (ctrl_r[`SCU_CB_TE] && !tdre_r) begin
            tx_load = 1'b1;
          end else begin
            tx_end    = 1'b1;
            txd_nxt   = 1'b1;
            tx_st_nxt = scu_pkg::SCU_TX_IDLE;
          end
        end
      end
      default: begin
        tx_st_nxt = scu_pkg::SCU_TX_IDLE;
      end
    endcase
    if (tx_load) begin
      tx_st_nxt = scu_pkg::SCU_TX_SHIFT;
      if (fmt.sync) begin
        txd_nxt    = tdr_r[0];
        tx_sh_nxt  = {4'hF, tdr_r[7:1]};
        tx_cnt_nxt = `SCU_SYNC_LAST;
      end else begin
        txd_nxt    = 1'b0;
        tx_sh_nxt  = frame_bits(fmt, tdr_r, ctrl_r[`SCU_CB_MPB_TX]);
        tx_cnt_nxt = frame_len(fmt);
      end
    end
    if (!ctrl_r[`SCU_CB_TE]) begin
      tx_st_nxt = scu_pkg::SCU_TX_IDLE;
      txd_nxt   = 1'b1;
    end
  end

  // Register file, holding buffers and sticky events; hardware sets win over clears.
  always_comb begin
    mode_nxt = mode_r;
    ctrl_nxt = ctrl_r;
    brr_nxt  = brr_r;
    tdr_nxt  = tdr_r;
    rdr_nxt  = rdr_r;
    ien_nxt  = ien_r;
    tdre_nxt = tdre_r;
    rdrf_nxt = rdrf_r;
    tend_nxt = tend_r;
    sts_nxt  = sts_r;
    ev       = '0;
    if (wr_en) begin
      case (paddr)
        `SCU_OFF_MODE:  mode_nxt = pwdata[7:0];
        `SCU_OFF_CTRL:  ctrl_nxt = pwdata[7:0];
        `SCU_OFF_BRR:   brr_nxt  = pwdata[7:0];
        `SCU_OFF_TDR: begin
          tdr_nxt  = pwdata[7:0];
          tdre_nxt = 1'b0;
          tend_nxt = 1'b0;
        end
        `SCU_OFF_CLEAR: sts_nxt  = sts_r & ~pwdata[`SCU_EV_W-1:0];
        `SCU_OFF_IEN:   ien_nxt  = pwdata[`SCU_EV_W-1:0];
        default: begin
        end
      endcase
    end
    if (rd_en && paddr == `SCU_OFF_RDR) begin
      rdrf_nxt = 1'b0;                                                  // Reading the data frees the buffer.
    end
    if (tx_load) begin
      tdre_nxt = 1'b1;
      ev[`SCU_EV_TXE] = 1'b1;
    end
    if (tx_end) begin
      tend_nxt = 1'b1;
      ev[`SCU_EV_TEND] = 1'b1;
    end
    if (!ctrl_r[`SCU_CB_TE]) begin
      tdre_nxt = 1'b1;
    end
    if (rx_done) begin
      if (rdrf_r) begin
        ev[`SCU_EV_OVERRUN_ERROR_FLAG] = 1'b1;                                        // Old data kept.
      end else if (rx_res.par_err || rx_res.frm_err) begin
        ev[`SCU_EV_PER] = rx_res.par_err;
        ev[`SCU_EV_FER] = rx_res.frm_err;
      end else begin
        rdr_nxt  = rx_res.data;
        rdrf_nxt = 1'b1;
        ev[`SCU_EV_RXF] = 1'b1;
      end
    end
    sts_nxt = sts_nxt | ev;
    irq_nxt = |(sts_nxt & ien_nxt);
  end

  // APB answer: pready rises in the access phase, one cycle after setup.
  always_comb begin
    pready_nxt  = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt  = '0;
    if (psel && !penable) begin
      case (paddr)
        `SCU_OFF_MODE:   prdata_nxt = {24'h000000, mode_r};
        `SCU_OFF_CTRL:   prdata_nxt = {24'h000000, ctrl_r};
        `SCU_OFF_BRR:    prdata_nxt = {24'h000000, brr_r};
        `SCU_OFF_TDR:    prdata_nxt = {24'h000000, tdr_r};
        `SCU_OFF_RDR:    prdata_nxt = {24'h000000, rdr_r};
        `SCU_OFF_STATUS: prdata_nxt = {26'h0000000, sts_r};
        `SCU_OFF_CLEAR:  prdata_nxt = '0;
        `SCU_OFF_IEN:    prdata_nxt = {26'h0000000, ien_r};
        `SCU_OFF_FLAGS: begin
          prdata_nxt[`SCU_FB_TDRE]   = tdre_r;
          prdata_nxt[`SCU_FB_RDRF]   = rdrf_r;
          prdata_nxt[`SCU_FB_TEND]   = tend_r;
          prdata_nxt[`SCU_FB_RXBUSY] = rx_busy;
          prdata_nxt[`SCU_FB_TXBUSY] = (tx_st_r != scu_pkg::SCU_TX_IDLE);
        end
        default:         pslverr_nxt = 1'b1;
      endcase
    end
  end

  // All top-level state and every output are registered here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r   <= `SCU_RST_MODE;
      ctrl_r   <= `SCU_RST_CTRL;
      brr_r    <= `SCU_RST_BRR;
      tdr_r    <= `SCU_RST_DATA;
      rdr_r    <= `SCU_RST_DATA;
      sts_r    <= '0;
      ien_r    <= '0;
      tdre_r   <= 1'b1;
      rdrf_r   <= 1'b0;
      tend_r   <= 1'b1;
      tx_st_r  <= scu_pkg::SCU_TX_IDLE;
      tx_sh_r  <= '1;
      tx_cnt_r <= '0;
      ph_r     <= '0;
      txd      <= 1'b1;
      sck_o    <= 1'b1;
      sck_oe   <= 1'b0;
      irq      <= 1'b0;
      prdata   <= '0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      mode_r   <= mode_nxt;
      ctrl_r   <= ctrl_nxt;
      brr_r    <= brr_nxt;
      tdr_r    <= tdr_nxt;
      rdr_r    <= rdr_nxt;
      sts_r    <= sts_nxt;
      ien_r    <= ien_nxt;
      tdre_r   <= tdre_nxt;
      rdrf_r   <= rdrf_nxt;
      tend_r   <= tend_nxt;
      tx_st_r  <= tx_st_nxt;
      tx_sh_r  <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      ph_r     <= ph_nxt;
      txd      <= txd_nxt;
      sck_o    <= sck_o_nxt;
      sck_oe   <= sck_oe_nxt;
      irq      <= irq_nxt;
      prdata   <= prdata_nxt;
      pready   <= pready_nxt;
      pslverr  <= pslverr_nxt;
    end
  end

endmodule

// [bench/scu_props.sv]
/* Port checker of the serial unit.
   Assumes binding to scu_top, one pclk domain. */
`timescale 1ns/10ps
module scu_props (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins.
  input wire logic        txd,
  input wire logic        sck_oe,
  input wire logic        irq
);
  logic [7:0] mode_r, mode_nxt, ctrl_r, ctrl_nxt;
  logic       wr, oe_exp;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow mode and control, since pin ownership depends on both.
  always_comb begin
    wr = psel && penable && pready && pwrite;
    mode_nxt = (wr && paddr == 8'h00) ? pwdata[7:0] : mode_r;
    ctrl_nxt = (wr && paddr == 8'h04) ? pwdata[7:0] : ctrl_r;
    oe_exp = !ctrl_r[1] && (mode_r[7] || ctrl_r[0]);
  end
  // Reset matches the design's register reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 8'h00;
      ctrl_r <= 8'h00;
    end else begin
      mode_r <= mode_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end
  sequence setup_s; psel && !penable; endsequence
  sequence answer_s; pready ##1 !pready; endsequence
  ready_once_a: assert property (setup_s |=> answer_s) else $error("late answer");
  ready_cause_a: assert property (pready |-> penable && $past(psel)) else $error("stray ready");
  err_clean_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("high bits");
  pin_owner_a: assert property (wr && paddr < 8'h08 |-> ##3 sck_oe == oe_exp) else $error("sck_oe");
  tx_idle_a: assert property (wr && paddr == 8'h04 && !pwdata[5] |-> ##3 txd [*4]) else $error("txd busy");
  start_len_a: assert property ($fell(txd) && !mode_r[7] |=> !txd [*8]) else $error("short bit");
  irq_mask_a: assert property (wr && paddr == 8'h1C && pwdata[7:0] == 8'h00 |-> ##[1:2] !irq) else $error("irq");
endmodule

bind scu_top scu_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .txd, .sck_oe, .irq);

// [bench/scu_peer.sv]
/* Remote asynchronous transmitter on the receive line.
   Assumes a bit time of sixteen pclk, as divisor zero gives. */
`timescale 1ns/10ps
module scu_peer (
  // Clock.
  input wire logic pclk,
  // Line to the unit.
  output logic     line
);
  // The line rests at mark between frames.
  initial line = 1'b1;
  // Frame bits leave from bit 0, so the start bit goes first.
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      repeat (16) @(posedge pclk);
    end
  endtask
endmodule

// [bench/scu_top_tb.sv]
/* Testbench of the serial unit: registers, clock pin, framing, interrupt.
   Assumes scu_props is bound and scu_peer drives rxd. */
`timescale 1ns/10ps
module scu_top_tb;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic        e;
  } scu_row_t;
  // Each clock source selection, read-backs and an unmapped read.
  localparam scu_row_t ROWS [8] = '{'{1, 8'h00, 32'h00, 0}, '{1, 8'h04, 32'h01, 0}, '{0, 8'h04, 32'h01, 0},
    '{1, 8'h04, 32'h02, 0}, '{1, 8'h00, 32'h80, 0}, '{0, 8'h00, 32'h80, 0}, '{1, 8'h04, 32'h00, 0},
    '{0, 8'h24, 32'h00, 1}};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic        pready, pslverr, txd, rx_line, sck_oe, irq;
  logic        sck_in = 1'b1;
  int          error_cnt = 0, total_checks = 0, n;
  always #25 pclk = ~pclk;
  scu_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .txd, .rxd(rx_line), .sck_i(sck_in), .sck_o(), .sck_oe, .irq);
  scu_peer peer (.pclk, .line(rx_line));
  task automatic complete_run;
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A wait that ran out ends the run as a failure.
  task automatic guard;
    if (n >= 200) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer; an idle cycle follows so strobes never toggle twice in a step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 200 && pready !== 1'b1; n++) @(posedge pclk);
    guard();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].w) chk("rdata", ROWS[i].d, q);
      chk("pslverr", 32'(ROWS[i].e), 32'(e));
    end
    // A second reset in mid-run must restore pins and registers.
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    chk("sck_oe", 32'h0, 32'(sck_oe));
    apb(0, 8'h08, 32'h0);
    chk("divisor", 32'h3, q);
    apb(0, 8'h20, 32'h0);
    chk("flags", 32'h5, q);
    // Even parity, 8 bits, one stop; a frame arrives while one leaves.
    apb(1, 8'h08, 32'h0);
    apb(1, 8'h00, 32'h20);
    apb(1, 8'h04, 32'h30);
    apb(1, 8'h1C, 32'h1);
    apb(1, 8'h0C, 32'hA5);
    fork
      peer.send({1'b1, ^8'h3C, 8'h3C, 1'b0});
    join_none
    for (n = 0; n < 200 && txd !== 1'b0; n++) @(posedge pclk);
    guard();
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      chk("txd", 32'({1'b1, ^8'hA5, 8'hA5, 1'b0} >> i) & 32'h1, 32'(txd));
      repeat (16) @(posedge pclk);
    end
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge pclk);
    guard();
    apb(0, 8'h10, 32'h0);
    chk("rx data", 32'h3C, q);
    apb(1, 8'h1C, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    // A wrong parity bit raises only the parity event.
    apb(1, 8'h18, 32'h3F);
    apb(1, 8'h1C, 32'h10);
    peer.send({1'b1, 1'b1, 8'h3C, 1'b0});
    chk("irq", 32'h1, 32'(irq));
    apb(0, 8'h14, 32'h0);
    chk("status", 32'h10, q);
    apb(1, 8'h18, 32'h10);
    chk("irq", 32'h0, 32'(irq));
    // Synchronous, pin clock: each falling edge puts out the next bit, LSB first.
    apb(1, 8'h00, 32'h80);
    apb(1, 8'h04, 32'h22);
    apb(1, 8'h0C, 32'hA5);
    for (int i = 0; i < 8; i++) begin
      sck_in <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("sync txd", 32'(8'hA5 >> i) & 32'h1, 32'(txd));
      sck_in <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    complete_run();
  end
endmodule
